// ==== bench/module_control_pin_sequencer_asserts.sv ====
// Checker of the control pins joining the host and modem ends
`timescale 1ns/1ps
module module_control_pin_sequencer_asserts #(
   parameter int unsigned OFF_CYC  = 20,
   parameter int unsigned BOOT_CYC = 4,
   parameter int unsigned RST_HOLD = 10
) (
   input wire logic clk_i,
   input wire logic arst_n_i,
   input wire logic power_on,
   input wire logic reset_n,
   input wire logic radio_kill_n,
   input wire logic rf_ind_o,
   input wire logic rf_ind_oe,
   input wire logic wake_o,
   input wire logic wake_oe,
   input wire logic rf_status_indicator_n,
   input wire logic host_wake_n
);
   // ----------------------------------------------------------------
   // Run lengths of power low, power high with kill and reset high, reset low
   // ----------------------------------------------------------------
   logic [31:0] lo_reg;
   logic [31:0] on_reg;
   logic [31:0] rl_reg;
   logic [31:0] lo_next;
   logic [31:0] on_next;
   logic [31:0] rl_next;

   always_comb
   begin
      lo_next = power_on ? 32'h0 : lo_reg + 32'h1;
      on_next = (power_on && radio_kill_n && reset_n) ? on_reg + 32'h1 : 32'h0;
      rl_next = reset_n ? 32'h0 : rl_reg + 32'h1;
   end

   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         lo_reg <= 32'h0;
         on_reg <= 32'h0;
         rl_reg <= 32'h0;
      end
      else
      begin
         lo_reg <= lo_next;
         on_reg <= on_next;
         rl_reg <= rl_next;
      end
   end

   // ----------------------------------------------------------------
   // Properties
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!arst_n_i);

   sequence kill_held;
      !radio_kill_n [*8];
   endsequence

   sequence cold_rise;
      $rose(power_on) && !rf_ind_oe;
   endsequence

   a_reset_quiets: assert property (!reset_n |-> !rf_ind_oe && !wake_oe)
      else $error("pin outputs active while reset pin low");
   a_power_off: assert property (lo_reg > OFF_CYC + 8 |-> !rf_ind_oe && !wake_oe)
      else $error("outputs active after long power low");
   a_default_on: assert property (on_reg == BOOT_CYC + 14 |-> rf_ind_oe)
      else $error("radio not on after power up");
   a_cold_boot: assert property (cold_rise |=> !rf_ind_oe [*4])
      else $error("radio on before boot delay");
   a_kill_off: assert property (kill_held |-> !rf_ind_oe)
      else $error("radio on while kill held low");
   a_kill_drop: assert property ($fell(radio_kill_n) |-> ##[1:8] !rf_ind_oe)
      else $error("radio not off after kill");
   a_rf_sinks: assert property (rf_ind_oe |-> !rf_ind_o && !rf_status_indicator_n)
      else $error("indicator not pulled low");
   a_wake_sinks: assert property (wake_oe |-> !wake_o && !host_wake_n)
      else $error("host wake not pulled low");
   a_reset_hold: assert property ($rose(reset_n) |-> rl_reg > RST_HOLD)
      else $error("reset pin low too briefly");
   a_reset_boot: assert property ($rose(reset_n) |-> !rf_ind_oe [*4])
      else $error("radio on right after reset release");
endmodule : module_control_pin_sequencer_asserts

// ==== bench/module_control_pin_sequencer_test.sv ====
// Self-checking bench for the host and modem control-pin ends
`timescale 1ns/1ps
module module_control_pin_sequencer_test;
   localparam int unsigned OFF_T  = 20;
   localparam int unsigned BOOT_T = 4;
   localparam int unsigned RST_T  = 10;

   typedef struct {
      logic        w;
      logic [7:0]  a;
      logic [31:0] d;
      logic [31:0] e;
      logic        er;
   } row_t;

   logic        clk_i     = 1'b0;
   logic        arst_n_i  = 1'b0;
   logic        psel      = 1'b0;
   logic        penable   = 1'b0;
   logic        pwrite    = 1'b0;
   logic [7:0]  paddr     = 8'h00;
   logic [31:0] pwdata    = 32'h0;
   logic        radio_we  = 1'b0;
   logic        radio_val = 1'b0;
   logic        pos_we    = 1'b0;
   logic        pos_val   = 1'b0;
   logic        wake      = 1'b0;
   logic        link_up   = 1'b0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        irq;
   logic        powered;
   logic        radio_on;
   logic        pos_on;
   logic        link_out;
   logic [31:0] rd;
   logic        er;
   int          num_errors = 0;
   int          num_checks = 0;
   row_t        rows [11] = '{
      '{1'b0, 8'h00, 32'h0, 32'h0, 1'b0}, '{1'b0, 8'h08, 32'h0, 32'h0, 1'b0},
      '{1'b0, 8'h0c, 32'h0, 32'h0, 1'b0}, '{1'b0, 8'h10, 32'h0, 32'h0, 1'b0},
      '{1'b1, 8'h10, 32'hffffffff, 32'h0, 1'b0},
      '{1'b0, 8'h10, 32'h0, 32'h7, 1'b0}, '{1'b1, 8'h00, 32'hc, 32'h0, 1'b0},
      '{1'b0, 8'h00, 32'h0, 32'hc, 1'b0}, '{1'b0, 8'h04, 32'h0, 32'h0, 1'b0},
      '{1'b1, 8'h14, 32'h5, 32'h0, 1'b1}, '{1'b0, 8'h14, 32'h0, 32'h0, 1'b1}};

   always #12.5 clk_i = ~clk_i;

   control_pins_if control_pins_if_i ();

   host_pin_ctl #(.PWR_HOLD(OFF_T + 8), .RST_HOLD(RST_T)) host_pin_ctl_i (
      .clk_i(clk_i), .arst_n_i(arst_n_i), .psel_i(psel),
      .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
      .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
      .pslverr_o(pslverr), .irq_o(irq), .pins(control_pins_if_i.host));

   modem_pin_end #(.OFF_CYC(OFF_T), .BOOT_CYC(BOOT_T)) modem_pin_end_i (
      .clk_i(clk_i), .arst_n_i(arst_n_i), .pins(control_pins_if_i.device),
      .radio_sw_we_i(radio_we), .radio_sw_val_i(radio_val),
      .pos_sw_we_i(pos_we), .pos_sw_val_i(pos_val), .wake_i(wake),
      .link_up_i(link_up), .powered_o(powered), .radio_on_o(radio_on),
      .pos_on_o(pos_on), .link_up_o(link_out));

   module_control_pin_sequencer_asserts #(.OFF_CYC(OFF_T),
      .BOOT_CYC(BOOT_T), .RST_HOLD(RST_T))
      module_control_pin_sequencer_asserts_i (
      .clk_i(clk_i), .arst_n_i(arst_n_i),
      .power_on(control_pins_if_i.power_on),
      .reset_n(control_pins_if_i.reset_n),
      .radio_kill_n(control_pins_if_i.radio_kill_n),
      .rf_ind_o(control_pins_if_i.rf_ind_o),
      .rf_ind_oe(control_pins_if_i.rf_ind_oe),
      .wake_o(control_pins_if_i.wake_o),
      .wake_oe(control_pins_if_i.wake_oe),
      .rf_status_indicator_n(control_pins_if_i.rf_status_indicator_n),
      .host_wake_n(control_pins_if_i.host_wake_n));

   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task tick(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask : tick

   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_i);
      penable <= 1'b1;
      do @(posedge clk_i); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e)
      begin
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
         num_errors++;
      end
   endtask : chk

   task chb(input string nm, input logic e, input logic g);
      chk(nm, {31'h0, e}, {31'h0, g});
   endtask : chb

   task wait_pwr(input logic v);
      for (int n = 0; n < 200 && powered !== v; n++) @(negedge clk_i);
      chb("powered", v, powered);
   endtask : wait_pwr

   task stop_test;
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : stop_test

   initial
   begin
      repeat (20000) @(posedge clk_i);
      num_errors++;
      stop_test();
   end

   // ----------------------------------------------------------------
   // Sequence of tests
   // ----------------------------------------------------------------
   initial
   begin
      repeat (3) @(posedge clk_i);
      arst_n_i <= 1'b1;
      tick(1);
      chb("power_on", 1'b0, control_pins_if_i.power_on);
      chb("reset_n", 1'b1, control_pins_if_i.reset_n);
      foreach (rows[k])
      begin
         apb(rows[k].w, rows[k].a, rows[k].d);
         if (!rows[k].w) chk("rdata", rows[k].e, rd);
         chb("pslverr", rows[k].er, er);
      end
      apb(1'b1, 8'h00, 32'h1);
      wait_pwr(1'b1);
      tick(6);
      chb("rf_ind", 1'b0, control_pins_if_i.rf_status_indicator_n);
      chb("radio_on", 1'b1, radio_on);
      chb("pos_on", 1'b1, pos_on);
      apb(1'b0, 8'h08, 32'h0);
      chk("status", 32'h2, rd);
      chb("irq", 1'b1, irq);
      apb(1'b1, 8'h0c, 32'h7);
      link_up <= 1'b1;
      apb(1'b1, 8'h00, 32'h5);
      tick(8);
      chb("rf_ind", 1'b1, control_pins_if_i.rf_status_indicator_n);
      chb("link", 1'b0, link_out);
      apb(1'b1, 8'h00, 32'h9);
      tick(8);
      chb("link", 1'b1, link_out);
      chb("pos_on", 1'b0, pos_on);
      apb(1'b1, 8'h00, 32'h1);
      tick(8);
      chb("pos_on", 1'b1, pos_on);
      radio_we <= 1'b1;
      pos_we <= 1'b1;
      @(posedge clk_i);
      radio_we <= 1'b0;
      pos_we <= 1'b0;
      tick(4);
      chb("radio_on", 1'b0, radio_on);
      chb("pos_on", 1'b0, pos_on);
      pos_we <= 1'b1;
      pos_val <= 1'b1;
      @(posedge clk_i);
      pos_we <= 1'b0;
      tick(4);
      chb("pos_on", 1'b1, pos_on);
      apb(1'b1, 8'h10, 32'h0);
      apb(1'b1, 8'h0c, 32'h7);
      wake <= 1'b1;
      tick(4);
      chb("wake_n", 1'b0, control_pins_if_i.host_wake_n);
      chb("irq", 1'b0, irq);
      apb(1'b0, 8'h08, 32'h0);
      chk("status", 32'h4, rd);
      apb(1'b1, 8'h10, 32'h1);
      tick(1);
      chb("irq", 1'b1, irq);
      wake <= 1'b0;
      apb(1'b1, 8'h0c, 32'h7);
      tick(3);
      chb("wake_n", 1'b1, control_pins_if_i.host_wake_n);
      chb("irq", 1'b0, irq);
      apb(1'b1, 8'h04, 32'h2);
      tick(2);
      chb("powered", 1'b0, powered);
      apb(1'b0, 8'h08, 32'h0);
      chk("status", 32'h1, rd);
      wait_pwr(1'b1);
      tick(2);
      chb("radio_on", 1'b1, radio_on);
      apb(1'b1, 8'h00, 32'h0);
      apb(1'b1, 8'h00, 32'h1);
      tick(OFF_T);
      chb("powered", 1'b1, powered);
      apb(1'b1, 8'h04, 32'h1);
      wait_pwr(1'b0);
      wait_pwr(1'b1);
      apb(1'b1, 8'h04, 32'h4);
      wait_pwr(1'b0);
      tick(OFF_T);
      chb("powered", 1'b0, powered);
      apb(1'b0, 8'h00, 32'h0);
      chk("ctrl", 32'h0, rd);
      apb(1'b1, 8'h00, 32'h1);
      wait_pwr(1'b1);
      arst_n_i <= 1'b0;
      tick(1);
      chb("powered", 1'b0, powered);
      arst_n_i <= 1'b1;
      tick(3);
      chb("power_on", 1'b0, control_pins_if_i.power_on);
      stop_test();
   end
endmodule : module_control_pin_sequencer_test

// ==== hw/host_pin_ctl.sv ====
// Host end: APB-controlled driver of the modem control pins
`timescale 1ns/1ps
module host_pin_ctl #(
   parameter int unsigned PWR_HOLD = ctl_pkg::OFF_CYC + ctl_pkg::HOLD_MARGIN,
   parameter int unsigned RST_HOLD = ctl_pkg::RST_CYC + ctl_pkg::HOLD_MARGIN
) (
   input  wire logic      clk_i,
   input  wire logic      arst_n_i,
   input  wire logic      psel_i,
   input  wire logic      penable_i,
   input  wire logic      pwrite_i,
   input  wire logic [7:0] paddr_i,
   input  wire logic [31:0] pwdata_i,
   output logic [31:0]    prdata_o,
   output logic           pready_o,
   output logic           pslverr_o,
   output logic           irq_o,
   control_pins_if.host   pins
);

   // ----------------------------------------------------------------
   // APB decode
   // ----------------------------------------------------------------
   logic acc;
   logic wr;
   logic hit;
   logic [31:0] rd_val;

   assign acc = psel_i & penable_i;
   assign wr  = acc & pwrite_i;

   logic [3:0] ctrl_reg;
   logic [3:0] ctrl_next;
   logic [2:0] irq_stat_reg;
   logic [2:0] irq_stat_next;
   logic [2:0] irq_mask_reg;
   logic [2:0] irq_mask_next;
   logic [31:0] prdata_reg;
   logic [31:0] prdata_next;
   logic [2:0] s1_reg;
   logic [2:0] s2_reg;
   logic [2:0] s3_reg;
   logic [1:0] filt_reg;
   logic [1:0] filt_prev_reg;
   logic [1:0] filt_next;
   ctl_pkg::seq_state_t       seq_reg;
   ctl_pkg::seq_state_t       seq_next;
   logic [ctl_pkg::CNT_W-1:0] cnt_reg;
   logic [ctl_pkg::CNT_W-1:0] cnt_next;
   logic restart_reg;
   logic restart_next;
   logic done;

   always_comb
   begin
      hit    = 1'b1;
      rd_val = 32'h0;
      if (paddr_i == ctl_pkg::CTRL_OFS)
      begin
         rd_val = {28'h0, ctrl_reg};
      end
      else if (paddr_i == ctl_pkg::CMD_OFS)
      begin
         rd_val = 32'h0;
      end
      else if (paddr_i == ctl_pkg::STATUS_OFS)
      begin
         rd_val = {29'h0, filt_reg, seq_reg != ctl_pkg::SEQ_IDLE};
      end
      else if (paddr_i == ctl_pkg::IRQ_STAT_OFS)
      begin
         rd_val = {29'h0, irq_stat_reg};
      end
      else if (paddr_i == ctl_pkg::IRQ_MASK_OFS)
      begin
         rd_val = {29'h0, irq_mask_reg};
      end
      else
      begin
         hit = 1'b0;
      end
      prdata_next = (psel_i & ~penable_i & ~pwrite_i) ? rd_val : prdata_reg;
   end

   assign pready_o  = 1'b1;
   assign pslverr_o = acc & ~hit;
   assign prdata_o  = prdata_reg;

   // ----------------------------------------------------------------
   // Status inputs: rf on (indicator low), wake asserted
   // ----------------------------------------------------------------
   assign filt_next = (s2_reg[1:0] & s3_reg[1:0]) |
                      (filt_reg & (s2_reg[1:0] | s3_reg[1:0]));

   // ----------------------------------------------------------------
   // Pin sequences and registers
   // ----------------------------------------------------------------
   always_comb
   begin
      seq_next     = seq_reg;
      cnt_next     = '0;
      restart_next = restart_reg;
      ctrl_next    = ctrl_reg;
      done         = 1'b0;
      if (wr && paddr_i == ctl_pkg::CTRL_OFS)
      begin
         ctrl_next = pwdata_i[3:0];
      end
      case (seq_reg)
         ctl_pkg::SEQ_IDLE:
         begin
            if (wr && paddr_i == ctl_pkg::CMD_OFS)
            begin
               if (pwdata_i[ctl_pkg::CMD_RESTART_BIT] ||
                   pwdata_i[ctl_pkg::CMD_SHUTDOWN_BIT])
               begin
                  seq_next     = ctl_pkg::SEQ_PWR_LOW; // [R04] [R08]
                  restart_next = pwdata_i[ctl_pkg::CMD_RESTART_BIT];
               end
               else if (pwdata_i[ctl_pkg::CMD_RSTPULSE_BIT])
               begin
                  seq_next = ctl_pkg::SEQ_RST_LOW; // [R07]
               end
            end
         end
         ctl_pkg::SEQ_PWR_LOW:
         begin
            cnt_next = cnt_reg + 1'b1;
            if (cnt_reg == PWR_HOLD[ctl_pkg::CNT_W-1:0])
            begin
               seq_next = ctl_pkg::SEQ_IDLE;
               done     = 1'b1;
               ctrl_next[ctl_pkg::CTRL_PWR_BIT] = restart_reg; // [R08]
            end
         end
         ctl_pkg::SEQ_RST_LOW:
         begin
            cnt_next = cnt_reg + 1'b1;
            if (cnt_reg == RST_HOLD[ctl_pkg::CNT_W-1:0])
            begin
               seq_next = ctl_pkg::SEQ_IDLE; // [R07]
               done     = 1'b1;
            end
         end
         default:
         begin
            seq_next = ctl_pkg::SEQ_IDLE;
         end
      endcase
      // Set wins over a same-cycle clear
      irq_stat_next = irq_stat_reg;
      if (wr && paddr_i == ctl_pkg::IRQ_STAT_OFS)
      begin
         irq_stat_next = irq_stat_reg & ~pwdata_i[2:0];
      end
      irq_stat_next = irq_stat_next |
                      {done,
                       filt_reg[0] ^ filt_prev_reg[0],
                       filt_reg[1] & ~filt_prev_reg[1]};
      irq_mask_next = irq_mask_reg;
      if (wr && paddr_i == ctl_pkg::IRQ_MASK_OFS)
      begin
         irq_mask_next = pwdata_i[2:0];
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         ctrl_reg      <= ctl_pkg::CTRL_RESET_VAL;
         irq_stat_reg  <= ctl_pkg::IRQ_RESET_VAL;
         irq_mask_reg  <= ctl_pkg::IRQ_RESET_VAL;
         prdata_reg    <= 32'h0;
         s1_reg        <= 3'h0;
         s2_reg        <= 3'h0;
         s3_reg        <= 3'h0;
         filt_reg      <= 2'h0;
         filt_prev_reg <= 2'h0;
         seq_reg       <= ctl_pkg::SEQ_IDLE;
         cnt_reg       <= '0;
         restart_reg   <= 1'b0;
      end
      else
      begin
         ctrl_reg      <= ctrl_next;
         irq_stat_reg  <= irq_stat_next;
         irq_mask_reg  <= irq_mask_next;
         prdata_reg    <= prdata_next;
         s1_reg        <= {1'b0, ~pins.host_wake_n,
                           ~pins.rf_status_indicator_n};
         s2_reg        <= s1_reg;
         s3_reg        <= s2_reg;
         filt_reg      <= filt_next;
         filt_prev_reg <= filt_reg;
         seq_reg       <= seq_next;
         cnt_reg       <= cnt_next;
         restart_reg   <= restart_next;
      end
   end

   assign irq_o = |(irq_stat_reg & irq_mask_reg);

   // Power always driven; others driven low only when asserted
   assign pins.pwr_oe   = 1'b1;
   assign pins.pwr_o    = ctrl_reg[ctl_pkg::CTRL_PWR_BIT] &
                          (seq_reg != ctl_pkg::SEQ_PWR_LOW); // [R04]
   assign pins.rst_o    = 1'b0;
   assign pins.rst_oe   = ctrl_reg[ctl_pkg::CTRL_RST_BIT] |
                          (seq_reg == ctl_pkg::SEQ_RST_LOW); // [R07]
   assign pins.rkill_o  = 1'b0;
   assign pins.rkill_oe = ctrl_reg[ctl_pkg::CTRL_RKILL_BIT];
   assign pins.pkill_o  = 1'b0;
   assign pins.pkill_oe = ctrl_reg[ctl_pkg::CTRL_PKILL_BIT];

endmodule : host_pin_ctl

// ==== hw/modem_pin_end.sv ====
// Modem end: power sequencing and control-pin handling
//
// Behaviour
// [R01] Powered on while power input high
// [R02] Power input weakly pulled low
// [R03] Power tied high: on with supply
// [R04] Power low over 500 ms shuts down
// [R05] Host keeps reset still during power-on
// [R06] Reset input acts asynchronously, immediately
// [R07] Reset low over 20 ms resets fully
// [R08] Power low then high restarts device
// [R09] Reset input pulled up always
// [R10] Reset discards data and network link
// [R11] Indicator sinks low while radio on
// [R12] Radio kill low forces radio off
// [R13] Otherwise software decides, default enabled
// [R14] Positioning kill low disables positioning
// [R15] Otherwise software decides, default enabled
// [R16] Wake pulls host-wake output low
// [R17] Inputs synchronised, low time counted
//
// Implementation choices: the register addresses and register access over APB.
`timescale 1ns/1ps
module modem_pin_end #(
   parameter int unsigned OFF_CYC  = ctl_pkg::OFF_CYC,
   parameter int unsigned BOOT_CYC = ctl_pkg::BOOT_CYC
) (
   input  wire logic      clk_i,
   input  wire logic      arst_n_i,
   control_pins_if.device pins,
   input  wire logic      radio_sw_we_i,
   input  wire logic      radio_sw_val_i,
   input  wire logic      pos_sw_we_i,
   input  wire logic      pos_sw_val_i,
   input  wire logic      wake_i,
   input  wire logic      link_up_i,
   output logic           powered_o,
   output logic           radio_on_o,
   output logic           pos_on_o,
   output logic           link_up_o
);

   // ----------------------------------------------------------------
   // Reset: asserted at once, released on the clock
   // ----------------------------------------------------------------
   logic       rst_raw_n;
   logic [1:0] rst_sync_reg;
   logic       rst_n;

   assign rst_raw_n = arst_n_i & pins.reset_n; // [R06] [R07] [R05]

   always_ff @(posedge clk_i or negedge rst_raw_n)
   begin
      if (!rst_raw_n)
      begin
         rst_sync_reg <= 2'h0;
      end
      else
      begin
         rst_sync_reg <= {rst_sync_reg[0], 1'b1};
      end
   end

   assign rst_n = rst_sync_reg[1];

   // ----------------------------------------------------------------
   // Input synchronisers: power, radio kill, positioning kill
   // ----------------------------------------------------------------
   localparam logic [2:0] IN_RST = 3'h6;

   logic [2:0] s1_reg;
   logic [2:0] s2_reg;
   logic [2:0] s3_reg;
   logic [2:0] filt_reg;
   logic [2:0] filt_next;
   logic       pwr_in;
   logic       rkill_n_in;
   logic       pkill_n_in;

   // Change accepted once stages two and three agree
   always_comb
   begin
      filt_next = (s2_reg & s3_reg) | (filt_reg & (s2_reg | s3_reg)); // [R17]
   end

   always_ff @(posedge clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s1_reg   <= IN_RST;
         s2_reg   <= IN_RST;
         s3_reg   <= IN_RST;
         filt_reg <= IN_RST;
      end
      else
      begin
         s1_reg   <= {pins.positioning_kill_n, pins.radio_kill_n,
                      pins.power_on};
         s2_reg   <= s1_reg;
         s3_reg   <= s2_reg;
         filt_reg <= filt_next;
      end
   end

   assign pwr_in     = filt_reg[0];
   assign rkill_n_in = filt_reg[1];
   assign pkill_n_in = filt_reg[2];

   // ----------------------------------------------------------------
   // Power state machine
   // ----------------------------------------------------------------
   ctl_pkg::pwr_state_t         state_reg;
   ctl_pkg::pwr_state_t         state_next;
   logic [ctl_pkg::CNT_W-1:0]   low_cnt_reg;
   logic [ctl_pkg::CNT_W-1:0]   low_cnt_next;
   logic [ctl_pkg::CNT_W-1:0]   boot_cnt_reg;
   logic [ctl_pkg::CNT_W-1:0]   boot_cnt_next;

   always_comb
   begin
      state_next    = state_reg;
      low_cnt_next  = '0;
      boot_cnt_next = '0;
      case (state_reg)
         ctl_pkg::PWR_OFF:
         begin
            if (pwr_in)
            begin
               state_next = ctl_pkg::PWR_BOOT; // [R01] [R03] [R08]
            end
         end
         ctl_pkg::PWR_BOOT,
         ctl_pkg::PWR_ON:
         begin
            if (!pwr_in)
            begin
               low_cnt_next = low_cnt_reg + 1'b1; // [R17]
               if (low_cnt_reg == OFF_CYC[ctl_pkg::CNT_W-1:0])
               begin
                  state_next   = ctl_pkg::PWR_OFF; // [R04] [R01]
                  low_cnt_next = '0;
               end
            end
            if (state_reg == ctl_pkg::PWR_BOOT)
            begin
               boot_cnt_next = boot_cnt_reg + 1'b1;
               if (boot_cnt_reg == BOOT_CYC[ctl_pkg::CNT_W-1:0] &&
                   state_next == ctl_pkg::PWR_BOOT)
               begin
                  state_next    = ctl_pkg::PWR_ON;
                  boot_cnt_next = '0;
               end
            end
         end
         default:
         begin
            state_next = ctl_pkg::PWR_OFF;
         end
      endcase
   end

   always_ff @(posedge clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_reg    <= ctl_pkg::PWR_OFF;
         low_cnt_reg  <= '0;
         boot_cnt_reg <= '0;
      end
      else
      begin
         state_reg    <= state_next;
         low_cnt_reg  <= low_cnt_next;
         boot_cnt_reg <= boot_cnt_next;
      end
   end

   // ----------------------------------------------------------------
   // Function enables, link and pin drivers
   // ----------------------------------------------------------------
   logic radio_sw_reg;
   logic radio_sw_next;
   logic pos_sw_reg;
   logic pos_sw_next;
   logic radio_on_reg;
   logic radio_on_next;
   logic pos_on_reg;
   logic pos_on_next;
   logic link_reg;
   logic link_next;
   logic wake_reg;
   logic wake_next;
   logic is_on;

   assign is_on = (state_reg == ctl_pkg::PWR_ON);

   always_comb
   begin
      radio_sw_next = radio_sw_reg;
      pos_sw_next   = pos_sw_reg;
      if (!is_on)
      begin
         radio_sw_next = 1'b1; // [R13]
         pos_sw_next   = 1'b1; // [R15]
      end
      else
      begin
         if (radio_sw_we_i)
         begin
            radio_sw_next = radio_sw_val_i; // [R13]
         end
         if (pos_sw_we_i)
         begin
            pos_sw_next = pos_sw_val_i; // [R15]
         end
      end
      radio_on_next = is_on & rkill_n_in & radio_sw_next; // [R12] [R13]
      pos_on_next   = is_on & pkill_n_in & pos_sw_next; // [R14] [R15]
      link_next     = radio_on_next & link_up_i; // [R10]
      wake_next     = is_on & wake_i; // [R16]
   end

   // Reset and power-off drop everything held
   always_ff @(posedge clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         radio_sw_reg <= 1'b1;
         pos_sw_reg   <= 1'b1;
         radio_on_reg <= 1'b0;
         pos_on_reg   <= 1'b0;
         link_reg     <= 1'b0; // [R10]
         wake_reg     <= 1'b0;
      end
      else
      begin
         radio_sw_reg <= radio_sw_next;
         pos_sw_reg   <= pos_sw_next;
         radio_on_reg <= radio_on_next;
         pos_on_reg   <= pos_on_next;
         link_reg     <= link_next;
         wake_reg     <= wake_next;
      end
   end

   // Open-drain: value always low, enable while asserted
   assign pins.rf_ind_o  = 1'b0;
   assign pins.rf_ind_oe = radio_on_reg; // [R11]
   assign pins.wake_o    = 1'b0;
   assign pins.wake_oe   = wake_reg; // [R16]

   assign powered_o  = is_on;
   assign radio_on_o = radio_on_reg;
   assign pos_on_o   = pos_on_reg;
   assign link_up_o  = link_reg;

endmodule : modem_pin_end

// ==== inc/control_pins_if.sv ====
// Control pins between host and modem, with pull resolution
`timescale 1ns/1ps
interface control_pins_if;
   logic pwr_o;
   logic pwr_oe;
   logic rst_o;
   logic rst_oe;
   logic rkill_o;
   logic rkill_oe;
   logic pkill_o;
   logic pkill_oe;
   logic rf_ind_o;
   logic rf_ind_oe;
   logic wake_o;
   logic wake_oe;
   logic power_on;
   logic reset_n;
   logic radio_kill_n;
   logic positioning_kill_n;
   logic rf_status_indicator_n;
   logic host_wake_n;

   // Weak pull-down on power, pull-ups elsewhere
   assign power_on              = pwr_oe ? pwr_o : 1'b0; // [R02]
   assign reset_n               = rst_oe ? rst_o : 1'b1; // [R09]
   assign radio_kill_n          = rkill_oe ? rkill_o : 1'b1;
   assign positioning_kill_n    = pkill_oe ? pkill_o : 1'b1;
   assign rf_status_indicator_n = rf_ind_oe ? rf_ind_o : 1'b1;
   assign host_wake_n           = wake_oe ? wake_o : 1'b1;

   modport device (
      input  power_on,
      input  reset_n,
      input  radio_kill_n,
      input  positioning_kill_n,
      output rf_ind_o,
      output rf_ind_oe,
      output wake_o,
      output wake_oe
   );

   modport host (
      output pwr_o,
      output pwr_oe,
      output rst_o,
      output rst_oe,
      output rkill_o,
      output rkill_oe,
      output pkill_o,
      output pkill_oe,
      input  rf_status_indicator_n,
      input  host_wake_n
   );
endinterface : control_pins_if

// ==== inc/ctl_pkg.sv ====
// Shared constants and types for the modem control-pin ends
package ctl_pkg;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int unsigned CLK_KHZ      = 40000;
   localparam int unsigned POWER_OFF_MS = 500;
   localparam int unsigned RESET_MS     = 20;
   localparam int unsigned OFF_CYC      = POWER_OFF_MS * CLK_KHZ;
   localparam int unsigned RST_CYC      = RESET_MS * CLK_KHZ;
   localparam int unsigned BOOT_CYC     = 64;
   localparam int unsigned HOLD_MARGIN  = 8;
   localparam int unsigned CNT_W        = 32;

   // ----------------------------------------------------------------
   // Register map of the controller
   // ----------------------------------------------------------------
   localparam logic [7:0] CTRL_OFS     = 8'h00;
   localparam logic [7:0] CMD_OFS      = 8'h04;
   localparam logic [7:0] STATUS_OFS   = 8'h08;
   localparam logic [7:0] IRQ_STAT_OFS = 8'h0c;
   localparam logic [7:0] IRQ_MASK_OFS = 8'h10;

   localparam int unsigned CTRL_PWR_BIT   = 0;
   localparam int unsigned CTRL_RST_BIT   = 1;
   localparam int unsigned CTRL_RKILL_BIT = 2;
   localparam int unsigned CTRL_PKILL_BIT = 3;
   localparam logic [3:0]  CTRL_RESET_VAL = 4'h0;

   localparam int unsigned CMD_RESTART_BIT  = 0;
   localparam int unsigned CMD_RSTPULSE_BIT = 1;
   localparam int unsigned CMD_SHUTDOWN_BIT = 2;

   localparam int unsigned ST_BUSY_BIT  = 0;
   localparam int unsigned ST_RFON_BIT  = 1;
   localparam int unsigned ST_WAKE_BIT  = 2;

   localparam int unsigned IRQ_WAKE_BIT = 0;
   localparam int unsigned IRQ_RF_BIT   = 1;
   localparam int unsigned IRQ_DONE_BIT = 2;
   localparam logic [2:0]  IRQ_RESET_VAL = 3'h0;

   // ----------------------------------------------------------------
   // State types
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      PWR_OFF  = 3'b001,
      PWR_BOOT = 3'b010,
      PWR_ON   = 3'b100
   } pwr_state_t;

   typedef enum logic [2:0] {
      SEQ_IDLE    = 3'b001,
      SEQ_PWR_LOW = 3'b010,
      SEQ_RST_LOW = 3'b100
   } seq_state_t;

endpackage : ctl_pkg
